//--- hdl/ppsr_pkg.sv
// package: register map, field positions and types of the panel power-down setup register bank
package ppsr_pkg;
  // ===========================================
  // register indices and port addresses
  localparam logic [15:0] PPSR_IDX_STATUS_UNLOCK = 16'h0006;
  localparam logic [15:0] PPSR_IDX_CHIP_STATUS = 16'h0007;
  localparam logic [15:0] PPSR_IDX_VEXP_INIT = 16'h0037;
  localparam logic [15:0] PPSR_IDX_COLOR_PANEL = 16'h003e;
  localparam logic [15:0] PPSR_IDX_PDOWN_REFRESH = 16'h003f;
  localparam logic [15:0] PPSR_PORT_WAKEUP = 16'h0102;
  localparam logic [15:0] PPSR_PORT_SETUP_EN = 16'h46e8;
  localparam logic [15:0] PPSR_PORT_SETUP_MASK = 16'hcfff;
  localparam logic [2:0] PPSR_WAKEUP_LOW = 3'h2;
  localparam logic [15:0] PPSR_PORT_PAL_RIDX = 16'h03c7;
  localparam logic [15:0] PPSR_PORT_PAL_WIDX = 16'h03c8;
  localparam logic [15:0] PPSR_PORT_PAL_DATA = 16'h03c9;
  // ===========================================
  // field positions
  localparam int PPSR_CP_BORDER_EN = 7;
  localparam int PPSR_CP_BORDER_WHITE = 6;
  localparam int PPSR_CP_COLOR = 5;
  localparam int PPSR_CP_SYNC_EXT = 4;
  localparam int PPSR_CP_CRT_SYNC = 2;
  localparam int PPSR_CP_FP_INV = 1;
  localparam int PPSR_CP_LP_INV = 0;
  localparam int PPSR_PD_EN = 7;
  localparam int PPSR_SU_SETUP = 4;
  localparam int PPSR_SU_ENABLE = 3;
  localparam int PPSR_WK_WAKE = 0;
  localparam int PPSR_MISC_COLOR = 0;
  localparam int PPSR_EXT_MODE_BIT = 6;
  localparam int PPSR_COMPAT_BIT = 1;
  localparam int PPSR_STRAP_TTL_BIT = 3;
  // unlock pattern X1X01XXX
  localparam logic [7:0] PPSR_UNLOCK_MASK = 8'h58;
  localparam logic [7:0] PPSR_UNLOCK_VAL = 8'h48;
  localparam logic [7:0] PPSR_RESET_BYTE = 8'h00;
  localparam logic [9:0] PPSR_REFRESH_BIAS = 10'h005;
  localparam int PPSR_REFRESH_SHIFT = 3;
  localparam logic [1:0] PPSR_PAL_LAST = 2'h2;
  localparam int PPSR_PAL_DEPTH = 256;
  // ===========================================
  // carrier types
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ppsr_host_s;
  typedef struct packed {
    logic [7:0] misc_out;
    logic [7:0] ext_mode;
    logic [7:0] compat;
    logic [7:0] strap_status;
  } ppsr_core_s;
  typedef enum logic [1:0] {
    PPSR_PAL_IDLE = 2'b00,
    PPSR_PAL_READ = 2'b01,
    PPSR_PAL_WRITE = 2'b10
  } ppsr_pal_e;
endpackage

//--- hdl/ppsr_palette_ram.sv
// file: palette memory, 256 entries of 18 bits, registered read data
`timescale 1ns/1ps
module ppsr_palette_ram
  import ppsr_pkg::*;
(
  input wire logic mclk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [17:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [17:0] rd_data_q
);
  logic [17:0] mem [PPSR_PAL_DEPTH];

  // no reset on the array: contents are undefined until loaded
  always_ff @(posedge mclk)
  begin
    if (clk_en && wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (clk_en)
    begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule // ppsr_palette_ram

//--- hdl/ppsr_regs.sv
// file: panel control, status lock, power-down refresh and setup ports of the display controller
`timescale 1ns/1ps
module ppsr_regs
  import ppsr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ppsr_host_s host,
  input wire logic idx_sel,
  output logic [7:0] rdata_q,
  output logic rdata_valid_q,
  input wire ppsr_core_s core,
  input wire logic video_dot_clock_tick,
  input wire logic tft_enabled,
  input wire logic crt_vsync,
  input wire logic crt_hsync,
  input wire logic low_dir_sig,
  input wire logic high_dir_sig,
  input wire logic line_pulse_raw,
  input wire logic frame_pulse_raw,
  input wire logic border_slot,
  input wire logic palette_src_strap,
  output logic low_byte_direction,
  output logic high_byte_direction,
  output logic line_pulse,
  output logic frame_pulse,
  output logic border_white,
  output logic color_panel_sel,
  output logic sync_ext_io,
  output logic general_pd_en,
  output logic refresh_req,
  output logic access_enabled,
  output logic setup_mode,
  output logic rom_page_strobe_n,
  output logic [2:0] rom_page_q,
  output logic external_palette_q,
  output logic palette_read_gate
);
  // ===========================================
  // state
  logic [7:0] color_panel_q;
  logic [7:0] pd_refresh_q;
  logic [3:0] scratch_q;
  logic unlocked_q;
  logic setup_q;
  logic io_en_q;
  logic wake_q;
  logic strobe_q;
  logic strap_taken_q;
  logic [10:0] refresh_cnt_q;
  ppsr_pal_e pal_mode_q;
  logic [7:0] pal_idx_q;
  logic [1:0] pal_phase_q;
  logic [11:0] pal_hold_q;
  logic [17:0] pal_rd;

  // ===========================================
  // decode
  wire live = access_enabled && !setup_q;
  wire wr = host.wr && clk_en;
  wire rd = host.rd && clk_en;
  wire is_ext = idx_sel && live;
  wire hit_unlock = is_ext && host.addr == PPSR_IDX_STATUS_UNLOCK;
  wire hit_status = is_ext && host.addr == PPSR_IDX_CHIP_STATUS && unlocked_q;
  wire hit_vexp = is_ext && host.addr == PPSR_IDX_VEXP_INIT;
  wire hit_cp = is_ext && host.addr == PPSR_IDX_COLOR_PANEL;
  wire hit_pd = is_ext && host.addr == PPSR_IDX_PDOWN_REFRESH;
  // alias ports 56e8/66e8/76e8 fall out of the partial decode
  // the setup port answers in every state, or setup mode could never be left
  wire hit_setup = !idx_sel && (host.addr & PPSR_PORT_SETUP_MASK) == PPSR_PORT_SETUP_EN;
  wire hit_wake = !idx_sel && setup_q && host.addr[2:0] == PPSR_WAKEUP_LOW;
  wire pal_port = !idx_sel && live;
  wire hit_ridx = pal_port && host.addr == PPSR_PORT_PAL_RIDX;
  wire hit_widx = pal_port && host.addr == PPSR_PORT_PAL_WIDX;
  wire hit_data = pal_port && host.addr == PPSR_PORT_PAL_DATA;
  wire unlock_match = (host.wdata & PPSR_UNLOCK_MASK) == PPSR_UNLOCK_VAL;
  wire pal_last = pal_phase_q == PPSR_PAL_LAST;
  wire pal_wr_step = wr && hit_data && pal_mode_q == PPSR_PAL_WRITE;
  wire pal_wr_commit = pal_wr_step && pal_last;
  wire pal_rd_step = rd && hit_data && pal_mode_q == PPSR_PAL_READ;

  wire [7:0] status_val = {scratch_q,
    core.misc_out[PPSR_MISC_COLOR],
    core.ext_mode[PPSR_EXT_MODE_BIT],
    core.compat[PPSR_COMPAT_BIT],
    core.strap_status[PPSR_STRAP_TTL_BIT]};
  wire [1:0] pal_status = (pal_mode_q == PPSR_PAL_WRITE) ? 2'h3 : 2'h0;
  wire [5:0] pal_byte = (pal_phase_q == 2'h0) ? pal_rd[17:12] :
    (pal_phase_q == 2'h1) ? pal_rd[11:6] : pal_rd[5:0];

  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = PPSR_RESET_BYTE;
    if (hit_status)
      rd_mux = status_val;
    else if (hit_cp)
      rd_mux = color_panel_q;
    else if (hit_pd)
      rd_mux = pd_refresh_q;
    else if (hit_wake)
      rd_mux = {7'h00, wake_q};
    else if (hit_ridx)
      rd_mux = {6'h00, pal_status};
    else if (hit_data)
      rd_mux = {2'h0, pal_byte};
  end

  // ===========================================
  // pins
  assign color_panel_sel = color_panel_q[PPSR_CP_COLOR];
  assign sync_ext_io = color_panel_q[PPSR_CP_SYNC_EXT];
  assign border_white = color_panel_q[PPSR_CP_BORDER_WHITE];
  // tft forcing assumes the crt sync inputs arrive active high
  wire vs = tft_enabled ? ~crt_vsync : crt_vsync;
  wire hs = tft_enabled ? ~crt_hsync : crt_hsync;
  assign low_byte_direction = color_panel_q[PPSR_CP_CRT_SYNC] ? vs : low_dir_sig;
  assign high_byte_direction = color_panel_q[PPSR_CP_CRT_SYNC] ? hs : high_dir_sig;
  wire lp_base = line_pulse_raw | (color_panel_q[PPSR_CP_BORDER_EN] & border_slot);
  assign line_pulse = lp_base ^ color_panel_q[PPSR_CP_LP_INV];
  assign frame_pulse = frame_pulse_raw ^ color_panel_q[PPSR_CP_FP_INV];
  assign general_pd_en = pd_refresh_q[PPSR_PD_EN];
  assign access_enabled = io_en_q || wake_q;
  assign setup_mode = setup_q;
  assign rom_page_strobe_n = ~strobe_q;
  assign palette_read_gate = rd && hit_data && external_palette_q;
  // refresh period: 8*(z+5) video clocks
  // eleven bits: the longest spacing, 8 * 132, overflows ten
  wire [10:0] refresh_period = ({4'h0, pd_refresh_q[6:0]} + {1'b0, PPSR_REFRESH_BIAS}) << PPSR_REFRESH_SHIFT;
  wire refresh_hit = refresh_cnt_q >= refresh_period - 11'h001;
  assign refresh_req = general_pd_en && video_dot_clock_tick && refresh_hit;

  // ===========================================
  // control registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      color_panel_q <= PPSR_RESET_BYTE;
      pd_refresh_q <= PPSR_RESET_BYTE;
    end
    else if (clk_en)
    begin
      if (wr && hit_cp)
        color_panel_q <= host.wdata;
      if (wr && hit_pd)
        pd_refresh_q <= host.wdata;
    end
  end

  // ===========================================
  // status lock and scratch; a locked status swallows writes and reads as zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scratch_q <= 4'h0;
      unlocked_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr && hit_status)
        scratch_q <= host.wdata[7:4];
      if (wr && hit_unlock)
        unlocked_q <= unlock_match;
    end
  end

  // ===========================================
  // setup port and wakeup
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      setup_q <= 1'b0;
      io_en_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr && hit_setup)
      begin
        setup_q <= host.wdata[PPSR_SU_SETUP];
        io_en_q <= host.wdata[PPSR_SU_ENABLE];
      end
      if (wr && hit_wake)
        wake_q <= host.wdata[PPSR_WK_WAKE];
    end
  end

  // ===========================================
  // rom page strobe: one low cycle per setup-port write, page bits held for the outside latch
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strobe_q <= 1'b0;
      rom_page_q <= 3'h0;
    end
    else if (clk_en)
    begin
      strobe_q <= wr && hit_setup;
      if (wr && hit_setup)
      begin
        rom_page_q <= host.wdata[2:0];
      end
    end
  end

  // ===========================================
  // strap is caught on the first enabled edge after release, not under reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_taken_q <= 1'b0;
      external_palette_q <= 1'b0;
    end
    else if (clk_en && !strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      external_palette_q <= palette_src_strap;
    end
  end

  // ===========================================
  // refresh spacing counter, stepped on video clock ticks
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      refresh_cnt_q <= 11'h000;
    else if (clk_en)
    begin
      if (!general_pd_en)
        refresh_cnt_q <= 11'h000;
      else if (video_dot_clock_tick)
        refresh_cnt_q <= refresh_hit ? 11'h000 : refresh_cnt_q + 11'h001;
    end
  end

  // ===========================================
  // palette access sequencing
  // a fresh index write restarts the colour triple, so a half-written entry is dropped
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pal_mode_q <= PPSR_PAL_IDLE;
      pal_idx_q <= 8'h00;
      pal_phase_q <= 2'h0;
    end
    else if (clk_en)
    begin
      if (wr && hit_ridx)
      begin
        pal_mode_q <= PPSR_PAL_READ;
        pal_idx_q <= host.wdata;
        pal_phase_q <= 2'h0;
      end
      else if (wr && hit_widx)
      begin
        pal_mode_q <= PPSR_PAL_WRITE;
        pal_idx_q <= host.wdata;
        pal_phase_q <= 2'h0;
      end
      else if (pal_wr_step || pal_rd_step)
      begin
        pal_phase_q <= pal_last ? 2'h0 : pal_phase_q + 2'h1;
        if (pal_last)
          pal_idx_q <= pal_idx_q + 8'h01;
      end
    end
  end

  // ===========================================
  // colour holding register
  // red and green wait here for blue, so the ram only ever sees whole entries
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pal_hold_q <= 12'h000;
    else if (clk_en && pal_wr_step)
    begin
      case (pal_phase_q)
        2'h0: pal_hold_q[11:6] <= host.wdata[5:0];
        2'h1: pal_hold_q[5:0] <= host.wdata[5:0];
        default: pal_hold_q <= pal_hold_q;
      endcase
    end
  end

  // ===========================================
  // read holding register follows index; contents valid one cycle after index change
  // the first data read wants one idle cycle after the index write
  ppsr_palette_ram u_ram (
    .mclk(mclk),
    .clk_en(clk_en),
    .wr_en(pal_wr_commit),
    .wr_addr(pal_idx_q),
    .wr_data({pal_hold_q, host.wdata[5:0]}),
    .rd_addr(pal_idx_q),
    .rd_data_q(pal_rd)
  );

  // ===========================================
  // read data register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= PPSR_RESET_BYTE;
      rdata_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_valid_q <= rd;
      if (rd)
        rdata_q <= rd_mux;
    end
  end
endmodule // ppsr_regs

//--- dv/ppsr_regs_monitor.sv
// checker: port-level assertions for the panel setup register bank
`timescale 1ns/1ps
module ppsr_regs_monitor
  import ppsr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ppsr_host_s host,
  input wire logic idx_sel,
  input wire logic [7:0] rdata_q,
  input wire logic rdata_valid_q,
  input wire logic tft_enabled,
  input wire logic crt_vsync,
  input wire logic low_dir_sig,
  input wire logic high_dir_sig,
  input wire logic low_byte_direction,
  input wire logic high_byte_direction,
  input wire logic general_pd_en,
  input wire logic refresh_req,
  input wire logic access_enabled,
  input wire logic setup_mode,
  input wire logic rom_page_strobe_n,
  input wire logic [2:0] rom_page_q,
  input wire logic palette_read_gate
);
  // ===========================================
  // decode helpers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire rd_d = clk_en && host.rd;
  wire [2:0] page_d = host.wdata[2:0];
  wire setup_d = host.wdata[PPSR_SU_SETUP];
  wire setup_wr = clk_en && host.wr && !idx_sel && ((host.addr & PPSR_PORT_SETUP_MASK) == PPSR_PORT_SETUP_EN);
  wire wake_wr = clk_en && host.wr && !idx_sel && setup_mode && (host.addr[2:0] == PPSR_WAKEUP_LOW)
    && host.wdata[PPSR_WK_WAKE];
  // the direction pins only leave their own signal when routed to the syncs
  wire routed = high_byte_direction != high_dir_sig;
  sequence strobe_pulse_s;
    !rom_page_strobe_n ##1 rom_page_strobe_n;
  endsequence
  // ===========================================
  // assertions
  rom_strobe_a: assert property (setup_wr |=> strobe_pulse_s)
    else $error("rom page strobe is not one low cycle");
  rom_page_a: assert property (setup_wr |=> rom_page_q == $past(page_d))
    else $error("rom page bits not latched");
  setup_mode_a: assert property (setup_wr |=> setup_mode == $past(setup_d))
    else $error("setup mode does not follow setup bit");
  wake_up_a: assert property (wake_wr |=> access_enabled)
    else $error("wakeup write did not enable access");
  gated_read_a: assert property (rd_d && !access_enabled && !setup_mode |=> rdata_q == 8'h00)
    else $error("disabled device returned data");
  read_valid_a: assert property (clk_en |=> rdata_valid_q == $past(rd_d))
    else $error("read valid not one cycle after read");
  dir_route_a: assert property (!tft_enabled && routed |-> low_byte_direction == crt_vsync)
    else $error("direction pins not routed as a pair");
  tft_sync_a: assert property (tft_enabled && routed |-> low_byte_direction == !crt_vsync)
    else $error("tft sync not active low");
  refresh_gap_a: assert property (refresh_req |-> general_pd_en ##1 (!refresh_req) [*8])
    else $error("refresh outside power-down or too close");
  pal_gate_a: assert property (palette_read_gate |-> host.rd && !idx_sel && host.addr == PPSR_PORT_PAL_DATA)
    else $error("palette gate without data read");
endmodule // ppsr_regs_monitor

bind ppsr_regs ppsr_regs_monitor u_ppsr_regs_monitor (.mclk, .reset_n, .clk_en, .host, .idx_sel, .rdata_q,
  .rdata_valid_q, .tft_enabled, .crt_vsync, .low_dir_sig, .high_dir_sig, .low_byte_direction,
  .high_byte_direction, .general_pd_en, .refresh_req, .access_enabled, .setup_mode, .rom_page_strobe_n,
  .rom_page_q, .palette_read_gate);

//--- dv/ppsr_host.sv
// host model: one-cycle read and write requests on the register bus
`timescale 1ns/1ps
module ppsr_host
  import ppsr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata_q,
  output ppsr_host_s host,
  output logic idx_sel
);
  initial
  begin
    host = '0;
    idx_sel = 1'b0;
  end
  // a released bus drops rd and wr and shows the inverse of its last address, data and select, never a stale copy
  task automatic xfer(input logic w, input logic ix, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge mclk);
    host = '{rd: !w, wr: w, addr: a, wdata: d};
    idx_sel = ix;
    @(negedge mclk);
    q = rdata_q;
    host = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    idx_sel = !ix;
  endtask
endmodule // ppsr_host

//--- dv/ppsr_regs_tb.sv
// testbench: register sequences for the panel setup register bank
`timescale 1ns/1ps
module ppsr_regs_tb;
  import ppsr_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  ppsr_host_s host;
  ppsr_core_s core = '{8'h01, 8'h40, 8'h02, 8'h08};
  logic idx_sel, rdata_valid_q, low_byte_direction, high_byte_direction, line_pulse, frame_pulse;
  logic border_white, color_panel_sel, sync_ext_io, general_pd_en, refresh_req, access_enabled;
  logic setup_mode, rom_page_strobe_n, external_palette_q, palette_read_gate;
  logic tft_enabled = 1'b0, crt_vsync = 1'b1, crt_hsync = 1'b0, low_dir_sig = 1'b0, high_dir_sig = 1'b1;
  logic line_pulse_raw = 1'b1, frame_pulse_raw = 1'b0, border_slot = 1'b0, tick = 1'b1, strap = 1'b1;
  logic [2:0] rom_page_q;
  logic [7:0] rdata_q, q;
  logic [7:0] cpv [4] = '{8'h00, 8'h36, 8'h59, 8'h85};
  logic [7:0] pal [6] = '{8'hff, 8'h15, 8'h2a, 8'h01, 8'h20, 8'h3e};
  int num_errors = 0;
  int checks_done = 0;
  int n;
  always #25 mclk = ~mclk;
  ppsr_host u_ppsr_host (.mclk(mclk), .rdata_q(rdata_q), .host(host), .idx_sel(idx_sel));
  ppsr_regs u_ppsr_regs (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .host(host), .idx_sel(idx_sel),
    .rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q), .core(core), .video_dot_clock_tick(tick),
    .tft_enabled(tft_enabled), .crt_vsync(crt_vsync), .crt_hsync(crt_hsync), .low_dir_sig(low_dir_sig),
    .high_dir_sig(high_dir_sig), .line_pulse_raw(line_pulse_raw), .frame_pulse_raw(frame_pulse_raw),
    .border_slot(border_slot), .palette_src_strap(strap), .low_byte_direction(low_byte_direction),
    .high_byte_direction(high_byte_direction), .line_pulse(line_pulse), .frame_pulse(frame_pulse),
    .border_white(border_white), .color_panel_sel(color_panel_sel), .sync_ext_io(sync_ext_io),
    .general_pd_en(general_pd_en), .refresh_req(refresh_req), .access_enabled(access_enabled),
    .setup_mode(setup_mode), .rom_page_strobe_n(rom_page_strobe_n), .rom_page_q(rom_page_q),
    .external_palette_q(external_palette_q), .palette_read_gate(palette_read_gate));
  // ===========================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wr(input logic ix, input logic [15:0] a, input logic [7:0] d);
    u_ppsr_host.xfer(1'b1, ix, a, d, q);
  endtask
  task automatic rdc(input logic ix, input logic [15:0] a, input logic [7:0] e);
    u_ppsr_host.xfer(1'b0, ix, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #500us;
    num_errors++;
    summarize();
  end
  // ===========================================
  // tests
  initial
  begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    rdc(1'b1, PPSR_IDX_COLOR_PANEL, 8'h00);
    wr(1'b0, 16'h56e8, 8'h0d);
    chk1(access_enabled, 1'b1);
    chk({5'h00, rom_page_q}, 8'h05);
    rdc(1'b1, PPSR_IDX_PDOWN_REFRESH, 8'h00);
    foreach (cpv[i])
    begin
      wr(1'b1, PPSR_IDX_COLOR_PANEL, cpv[i]);
      rdc(1'b1, PPSR_IDX_COLOR_PANEL, cpv[i]);
      chk1(border_white, cpv[i][6]);
      chk1(color_panel_sel, cpv[i][5]);
      chk1(sync_ext_io, cpv[i][4]);
      chk1(line_pulse, line_pulse_raw ^ cpv[i][0]);
      chk1(frame_pulse, frame_pulse_raw ^ cpv[i][1]);
      chk1(low_byte_direction, cpv[i][2] ? crt_vsync : low_dir_sig);
      chk1(high_byte_direction, cpv[i][2] ? crt_hsync : high_dir_sig);
    end
    line_pulse_raw = 1'b0;
    border_slot = 1'b1;
    tft_enabled = 1'b1;
    high_dir_sig = 1'b0;
    #1;
    chk1(line_pulse, 1'b0);
    chk1(low_byte_direction, !crt_vsync);
    chk1(high_byte_direction, !crt_hsync);
    rdc(1'b1, PPSR_IDX_CHIP_STATUS, 8'h00);
    wr(1'b1, PPSR_IDX_STATUS_UNLOCK, 8'hcf);
    wr(1'b1, PPSR_IDX_CHIP_STATUS, 8'ha0);
    rdc(1'b1, PPSR_IDX_CHIP_STATUS, 8'haf);
    core = '0;
    wr(1'b1, PPSR_IDX_CHIP_STATUS, 8'h5f);
    rdc(1'b1, PPSR_IDX_CHIP_STATUS, 8'h50);
    wr(1'b1, PPSR_IDX_STATUS_UNLOCK, 8'h40);
    rdc(1'b1, PPSR_IDX_CHIP_STATUS, 8'h00);
    wr(1'b1, PPSR_IDX_VEXP_INIT, 8'hff);
    rdc(1'b1, PPSR_IDX_VEXP_INIT, 8'h00);
    // z of 1 gives a spacing of 8 * 6 ticks, one tick per cycle here
    wr(1'b1, PPSR_IDX_PDOWN_REFRESH, 8'h81);
    chk1(general_pd_en, 1'b1);
    n = 0;
    while (refresh_req !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (refresh_req !== 1'b1 && n < 200);
    chk(n[7:0], 8'h30);
    wr(1'b1, PPSR_IDX_PDOWN_REFRESH, 8'h00);
    chk1(general_pd_en, 1'b0);
    wr(1'b0, PPSR_PORT_SETUP_EN, 8'h10);
    chk1(setup_mode, 1'b1);
    chk1(access_enabled, 1'b0);
    rdc(1'b1, PPSR_IDX_COLOR_PANEL, 8'h00);
    wr(1'b0, 16'hfffa, 8'h01);
    chk1(access_enabled, 1'b1);
    wr(1'b0, 16'h76e8, 8'h08);
    chk1(setup_mode, 1'b0);
    // entries fe and ff, so the index steps across its top value
    wr(1'b0, PPSR_PORT_PAL_WIDX, 8'hfe);
    foreach (pal[i])
      wr(1'b0, PPSR_PORT_PAL_DATA, pal[i]);
    rdc(1'b0, PPSR_PORT_PAL_RIDX, 8'h03);
    wr(1'b0, PPSR_PORT_PAL_RIDX, 8'hfe);
    rdc(1'b0, PPSR_PORT_PAL_RIDX, 8'h00);
    foreach (pal[i])
      rdc(1'b0, PPSR_PORT_PAL_DATA, pal[i] & 8'h3f);
    chk1(external_palette_q, 1'b1);
    // mid-run reset with the strap low: registers clear and the strap is caught afresh
    strap = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    rdc(1'b1, PPSR_IDX_COLOR_PANEL, 8'h00);
    chk1(external_palette_q, 1'b0);
    chk({5'h00, rom_page_q}, 8'h00);
    summarize();
  end
endmodule // ppsr_regs_tb
